// *** design/ppa_defines.svh ***
// Register offsets, field positions and reset values of the phase adjust block
`ifndef PPA_DEFINES_SVH
`define PPA_DEFINES_SVH

`define PPA_ADDR_W        4
`define PPA_DATA_W        8
`define PPA_REG_CTRL      4'h0
`define PPA_REG_TRIM      4'h1
`define PPA_REG_NP1       4'h2
`define PPA_REG_NP2       4'h3
`define PPA_REG_NP3       4'h4
`define PPA_REG_FBDIV     4'h5
`define PPA_REG_STATUS    4'h6

`define PPA_CTRL_SLIP     0
`define PPA_CTRL_FBSRC    1
`define PPA_CTRL_MON0     2
`define PPA_CTRL_MON1     3
`define PPA_CTRL_SE_EN    4
`define PPA_CTRL_FINE_EN  5

`define PPA_ST_LOCK       0
`define PPA_ST_DIR        1
`define PPA_ST_PHASE      2
`define PPA_ST_RANGE      3

`define PPA_CTRL_RST      8'h00
`define PPA_TRIM_RST      8'h00
`define PPA_DIV_RST       8'h01
`define PPA_TRIM_W        4

`endif

// *** design/ppa_pkg.sv ***
// Types shared by the phase adjust and monitor block
package ppa_pkg;
    typedef enum logic [1:0] {
        PPA_MON_LOCK,
        PPA_MON_RANGE,
        PPA_MON_PHASE,
        PPA_MON_FBCLK
    } ppa_mon_mode_t;
endpackage

// *** design/ppa_div_stage.sv ***
// One programmable divider stage of the post divider cascade
`timescale 1ns/100ps
`default_nettype none
module ppa_div_stage #(
    parameter int W = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] modulus,
    output logic              tick_out
);
    import ppa_pkg::*;

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         tick_reg;
    logic         tick_next;

    // Modulus zero behaves as one, so a stage never stalls the chain
    always_comb
    begin
        cnt_next  = cnt_reg;
        tick_next = 1'b0;
        if (tick_in)
        begin
            if ((cnt_reg + {{(W-1){1'b0}}, 1'b1}) >= modulus)
            begin
                cnt_next  = '0;
                tick_next = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_out = tick_reg;
endmodule
`default_nettype wire

// *** design/ppa_phase_adjust.sv ***
// Post divider, clock gobbler, phase sampling and monitor mux of the clock synthesiser
//
// How it works
// R1: Post divider output keeps nominal 50/50 duty
// R2: Gobbler removes one oscillator pulse before divider
// R3: Each slip rise delays output one period
// R4: Host selects divider input source before slipping
// R5: Feedback source one clocks feedback from output
// R6: Host keeps feedback modulus multiple of post
// R7: Output sampled by feedback clock sets flag
// R8: Host slips until phase flag changes state
// R9: Mode 10 drives phase flag on monitor
// R10: Mode 10 readback bit shows phase flag
// R11: Mode 11 routes feedback divider clock out
// R12: Monitor pin driven only when enable set
// R13: Four-bit coarse trim selects load capacitance
// R14: Fine tuning follows the fine enable bit
// R15: Unlock raises a lock error indication
// R16: Detect oscillator leaving fine tune range
// R17: Capture range direction at loss of lock
// R18: Mode 00 drives pin low when unlocked
// R19: Mode 00 readback bit shows lock status
// R20: Post divider is three cascaded programmable stages
// R21: Mode 01 shows direction, updated on unlock
// R22: Slip bit synchronised, rising edge detected
// R23: Status flags synchronised before readback
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ppa_defines.svh"
module ppa_phase_adjust #(
    parameter int NP_W = 4,
    parameter int FB_W = 8
) (
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic [`PPA_ADDR_W-1:0]   addr,
    input  wire logic [`PPA_DATA_W-1:0]   wdata,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    output logic      [`PPA_DATA_W-1:0]   rdata,
    input  wire logic                     xtal_lock_in,
    input  wire logic                     tune_high_in,
    input  wire logic                     tune_low_in,
    output logic                          diff_clock_out_p,
    output logic                          diff_clock_out_n,
    output logic                          monitor_pin_out,
    output logic                          monitor_pin_oe,
    output logic      [`PPA_TRIM_W-1:0]   coarse_load_trim,
    output logic                          fine_tune_enable,
    output logic                          lock_error,
    output logic                          range_exceeded
);
    import ppa_pkg::*;

    localparam int TOT_W = 3 * NP_W;

    // Register file
    logic [`PPA_DATA_W-1:0] ctrl_reg, ctrl_next;
    logic [`PPA_TRIM_W-1:0] trim_reg, trim_next;
    logic [NP_W-1:0]        np1_reg, np1_next, np2_reg, np2_next, np3_reg, np3_next;
    logic [FB_W-1:0]        fb_reg, fb_next;
    logic [`PPA_DATA_W-1:0] rdata_reg, rdata_next;

    // Synchronisers and status
    logic       slip_s1_reg, slip_s2_reg, slip_s3_reg;
    logic       lock_s1_reg, lock_s2_reg, lock_d_reg;
    logic       hi_s1_reg, hi_s2_reg, lo_s1_reg, lo_s2_reg;
    logic       phase_s1_reg, phase_s2_reg;
    logic       dir_reg, dir_next;
    logic       lock_err_reg, range_reg;

    // Divider datapath
    logic             vco_tick;
    logic             t1, t2, t3;
    logic [TOT_W-1:0] ph_reg, ph_next;
    logic             clk_out_reg, clk_out_next;
    logic             clk_out_d_reg;
    logic [FB_W-1:0]  fbc_reg, fbc_next;
    logic             fbclk_reg, fbclk_next;
    logic             fbclk_d_reg;
    logic             phase_flag_reg, phase_flag_next;
    logic             fb_src_tick;
    logic             mon_reg, mon_next;
    logic             oe_reg;
    ppa_mon_mode_t    mode;

    function automatic ppa_mon_mode_t decode_mode(input logic [1:0] sel);
        ppa_mon_mode_t m;
        m = PPA_MON_LOCK;
        if (sel == 2'b01)
            m = PPA_MON_RANGE;
        else if (sel == 2'b10)
            m = PPA_MON_PHASE;
        else if (sel == 2'b11)
            m = PPA_MON_FBCLK;
        return m;
    endfunction

    // Zero moduli count as one
    function automatic logic [TOT_W-1:0] eff_mod(input logic [NP_W-1:0] v);
        return (v == '0) ? TOT_W'(1) : TOT_W'(v);
    endfunction

    assign mode = decode_mode({ctrl_reg[`PPA_CTRL_MON1], ctrl_reg[`PPA_CTRL_MON0]});

    // Register writes; read data stands one cycle after the strobe
    always_comb
    begin
        ctrl_next  = ctrl_reg;
        trim_next  = trim_reg;
        np1_next   = np1_reg;
        np2_next   = np2_reg;
        np3_next   = np3_reg;
        fb_next    = fb_reg;
        rdata_next = '0;
        if (wr_en)
        begin
            if (addr == `PPA_REG_CTRL)
                ctrl_next = wdata;
            else if (addr == `PPA_REG_TRIM)
                trim_next = wdata[`PPA_TRIM_W-1:0];  // [R13]
            else if (addr == `PPA_REG_NP1)
                np1_next = wdata[NP_W-1:0];
            else if (addr == `PPA_REG_NP2)
                np2_next = wdata[NP_W-1:0];
            else if (addr == `PPA_REG_NP3)
                np3_next = wdata[NP_W-1:0];
            else if (addr == `PPA_REG_FBDIV)
                fb_next = wdata[FB_W-1:0];
        end
        if (rd_en)
        begin
            if (addr == `PPA_REG_CTRL)
            begin
                rdata_next = ctrl_reg;
                case (mode)
                    PPA_MON_LOCK:  rdata_next[`PPA_CTRL_MON1] = lock_s2_reg;   // [R19]
                    PPA_MON_RANGE: rdata_next[`PPA_CTRL_MON1] = dir_reg;       // [R21]
                    PPA_MON_PHASE: rdata_next[`PPA_CTRL_MON1] = phase_s2_reg;  // [R10]
                    default:       rdata_next[`PPA_CTRL_MON1] = ctrl_reg[`PPA_CTRL_MON1];
                endcase
            end
            else if (addr == `PPA_REG_TRIM)
                rdata_next = `PPA_DATA_W'(trim_reg);
            else if (addr == `PPA_REG_NP1)
                rdata_next = `PPA_DATA_W'(np1_reg);
            else if (addr == `PPA_REG_NP2)
                rdata_next = `PPA_DATA_W'(np2_reg);
            else if (addr == `PPA_REG_NP3)
                rdata_next = `PPA_DATA_W'(np3_reg);
            else if (addr == `PPA_REG_FBDIV)
                rdata_next = `PPA_DATA_W'(fb_reg);
            else if (addr == `PPA_REG_STATUS)
            begin
                rdata_next[`PPA_ST_LOCK]  = lock_s2_reg;
                rdata_next[`PPA_ST_DIR]   = dir_reg;
                rdata_next[`PPA_ST_PHASE] = phase_s2_reg;
                rdata_next[`PPA_ST_RANGE] = range_reg;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg  <= `PPA_CTRL_RST;
            trim_reg  <= `PPA_TRIM_W'(`PPA_TRIM_RST);
            np1_reg   <= NP_W'(`PPA_DIV_RST);
            np2_reg   <= NP_W'(`PPA_DIV_RST);
            np3_reg   <= NP_W'(`PPA_DIV_RST);
            fb_reg    <= FB_W'(`PPA_DIV_RST);
            rdata_reg <= '0;
        end
        else
        begin
            ctrl_reg  <= ctrl_next;
            trim_reg  <= trim_next;
            np1_reg   <= np1_next;
            np2_reg   <= np2_next;
            np3_reg   <= np3_next;
            fb_reg    <= fb_next;
            rdata_reg <= rdata_next;
        end
    end

    // Gobbler: the slip bit rise removes exactly one oscillator tick
    assign vco_tick = ~(slip_s2_reg & ~slip_s3_reg);  // [R2] [R3] [R22]

    // Three cascaded stages, overall modulus is their product
    ppa_div_stage #(.W(NP_W)) u_np1 (
        .clk      (clk),
        .rst      (rst),
        .tick_in  (vco_tick),
        .modulus  (np1_reg),
        .tick_out (t1)
    );  // [R20]
    ppa_div_stage #(.W(NP_W)) u_np2 (
        .clk      (clk),
        .rst      (rst),
        .tick_in  (t1),
        .modulus  (np2_reg),
        .tick_out (t2)
    );  // [R20]
    ppa_div_stage #(.W(NP_W)) u_np3 (
        .clk      (clk),
        .rst      (rst),
        .tick_in  (t2),
        .modulus  (np3_reg),
        .tick_out (t3)
    );  // [R20]

    // Duty counter restarts on each cascade wrap; odd moduli get the extra tick high,
    // so duty is nominal within one oscillator period
    always_comb
    begin
        logic [TOT_W-1:0] tot;
        tot          = TOT_W'(eff_mod(np1_reg) * eff_mod(np2_reg) * eff_mod(np3_reg));
        ph_next      = ph_reg;
        clk_out_next = clk_out_reg;
        if (t3)
            ph_next = '0;
        else if (vco_tick && (ph_reg != {TOT_W{1'b1}}))
            ph_next = ph_reg + TOT_W'(1);
        clk_out_next = (ph_next < ((tot + TOT_W'(1)) >> 1));  // [R1]
    end

    // Feedback divider source: gobbled input or post divider output
    assign fb_src_tick = ctrl_reg[`PPA_CTRL_FBSRC] ? t3 : vco_tick;  // [R5] [R4]

    always_comb
    begin
        fbc_next        = fbc_reg;
        fbclk_next      = fbclk_reg;
        phase_flag_next = phase_flag_reg;
        if (fb_src_tick)
        begin
            if ((fbc_reg + FB_W'(1)) >= fb_reg)
            begin
                fbc_next   = '0;
                fbclk_next = 1'b1;
            end
            else
            begin
                fbc_next = fbc_reg + FB_W'(1);
                if (fbc_reg + FB_W'(1) >= (fb_reg >> 1))
                    fbclk_next = 1'b0;
            end
        end
        // Flag follows the output level seen at each feedback rising edge
        if (fbclk_reg && !fbclk_d_reg)
            phase_flag_next = clk_out_d_reg;  // [R7]
    end

    // Monitor mux; pin released when single ended output is off
    always_comb
    begin
        case (mode)
            PPA_MON_LOCK:  mon_next = lock_s2_reg;     // [R18]
            PPA_MON_RANGE: mon_next = dir_reg;         // [R21]
            PPA_MON_PHASE: mon_next = phase_flag_reg;  // [R9]
            default:       mon_next = fbclk_reg;       // [R11]
        endcase
        dir_next = dir_reg;
        if (lock_d_reg && !lock_s2_reg)
            dir_next = hi_s2_reg;  // [R17] [R21]
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ph_reg         <= '0;
            clk_out_reg    <= 1'b0;
            clk_out_d_reg  <= 1'b0;
            fbc_reg        <= '0;
            fbclk_reg      <= 1'b0;
            fbclk_d_reg    <= 1'b0;
            phase_flag_reg <= 1'b0;
            mon_reg        <= 1'b0;
            oe_reg         <= 1'b0;
            dir_reg        <= 1'b0;
        end
        else
        begin
            ph_reg         <= ph_next;
            clk_out_reg    <= clk_out_next;
            clk_out_d_reg  <= clk_out_reg;
            fbc_reg        <= fbc_next;
            fbclk_reg      <= fbclk_next;
            fbclk_d_reg    <= fbclk_reg;
            phase_flag_reg <= phase_flag_next;
            mon_reg        <= mon_next;
            oe_reg         <= ctrl_reg[`PPA_CTRL_SE_EN];  // [R12]
            dir_reg        <= dir_next;
        end
    end

    // Two-flop synchronisers; first stages feed only the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            slip_s1_reg  <= 1'b0;
            slip_s2_reg  <= 1'b0;
            slip_s3_reg  <= 1'b0;
            lock_s1_reg  <= 1'b0;
            lock_s2_reg  <= 1'b0;
            lock_d_reg   <= 1'b0;
            hi_s1_reg    <= 1'b0;
            hi_s2_reg    <= 1'b0;
            lo_s1_reg    <= 1'b0;
            lo_s2_reg    <= 1'b0;
            phase_s1_reg <= 1'b0;
            phase_s2_reg <= 1'b0;
            lock_err_reg <= 1'b0;
            range_reg    <= 1'b0;
        end
        else
        begin
            slip_s1_reg  <= ctrl_reg[`PPA_CTRL_SLIP];  // [R22]
            slip_s2_reg  <= slip_s1_reg;
            slip_s3_reg  <= slip_s2_reg;
            lock_s1_reg  <= xtal_lock_in;              // [R23]
            lock_s2_reg  <= lock_s1_reg;
            lock_d_reg   <= lock_s2_reg;
            hi_s1_reg    <= tune_high_in;
            hi_s2_reg    <= hi_s1_reg;
            lo_s1_reg    <= tune_low_in;
            lo_s2_reg    <= lo_s1_reg;
            phase_s1_reg <= phase_flag_reg;            // [R23]
            phase_s2_reg <= phase_s1_reg;
            lock_err_reg <= ~lock_s2_reg;              // [R15]
            range_reg    <= hi_s2_reg | lo_s2_reg;     // [R16]
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            diff_clock_out_p <= 1'b0;
            diff_clock_out_n <= 1'b1;
            coarse_load_trim <= '0;
            fine_tune_enable <= 1'b0;
        end
        else
        begin
            diff_clock_out_p <= clk_out_reg;
            diff_clock_out_n <= ~clk_out_reg;
            coarse_load_trim <= trim_reg;                       // [R13]
            fine_tune_enable <= ctrl_reg[`PPA_CTRL_FINE_EN];    // [R14]
        end
    end

    assign rdata           = rdata_reg;
    assign monitor_pin_out = mon_reg;
    assign monitor_pin_oe  = oe_reg;   // [R12]
    assign lock_error      = lock_err_reg;
    assign range_exceeded  = range_reg;
endmodule
`default_nettype wire

// *** dv/ppa_phase_adjust_props.sv ***
// Port checks for the phase adjust block
`timescale 1ns/100ps
`default_nettype none
`include "ppa_defines.svh"
module ppa_phase_adjust_props (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire logic [`PPA_ADDR_W-1:0] addr,
    input wire logic [`PPA_DATA_W-1:0] wdata,
    input wire logic                   wr_en,
    input wire logic                   rd_en,
    input wire logic [`PPA_DATA_W-1:0] rdata,
    input wire logic                   xtal_lock_in,
    input wire logic                   tune_high_in,
    input wire logic                   diff_clock_out_p,
    input wire logic                   diff_clock_out_n,
    input wire logic                   monitor_pin_out,
    input wire logic                   monitor_pin_oe,
    input wire logic [`PPA_TRIM_W-1:0] coarse_load_trim,
    input wire logic                   fine_tune_enable,
    input wire logic                   lock_error,
    input wire logic                   range_exceeded
);
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic [3:0] trm_reg;
    logic [3:0] trm_next;
    // Shadow of host writes, since control bits are not ports
    always_comb
    begin
        ctl_next = ctl_reg;
        trm_next = trm_reg;
        if (wr_en && addr == `PPA_REG_CTRL)
            ctl_next = wdata;
        if (wr_en && addr == `PPA_REG_TRIM)
            trm_next = wdata[3:0];
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctl_reg <= 8'h00;
            trm_reg <= 4'h0;
        end
        else
        begin
            ctl_reg <= ctl_next;
            trm_reg <= trm_next;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence mode_s(m);
        ctl_reg[3:2] == m && ctl_reg[4];
    endsequence
    sequence drop_s;
        $fell(xtal_lock_in);
    endsequence
    pair_diff_a: assert property (diff_clock_out_p != diff_clock_out_n)
        else $error("output pair not complementary");
    oe_follow_a: assert property (monitor_pin_oe == $past(ctl_reg[4]))
        else $error("monitor enable wrong");
    fine_follow_a: assert property (fine_tune_enable == $past(ctl_reg[5]))
        else $error("fine enable wrong");
    trim_follow_a: assert property (coarse_load_trim == $past(trm_reg))
        else $error("coarse trim wrong");
    lock_err_a: assert property (drop_s |-> ##[2:4] lock_error)
        else $error("no lock error on unlock");
    relock_clear_a: assert property ($rose(xtal_lock_in) |-> ##[2:4] !lock_error)
        else $error("lock error stuck");
    range_flag_a: assert property ($rose(tune_high_in) |-> ##[2:4] range_exceeded)
        else $error("range not flagged");
    lock_pin_a: assert property (mode_s(2'b00) [*3] |-> monitor_pin_out == !lock_error)
        else $error("lock pin wrong");
    dir_pin_a: assert property (drop_s ##1 mode_s(2'b01) [*6]
        |-> monitor_pin_out == $past(tune_high_in, 6))
        else $error("direction pin wrong");
    lock_read_a: assert property ((!lock_error) [*6] ##0 (rd_en && addr == `PPA_REG_CTRL
        && ctl_reg[3:2] == 2'b00) |=> rdata[3])
        else $error("lock readback wrong");
endmodule
bind ppa_phase_adjust ppa_phase_adjust_props props_u (.clk(clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .xtal_lock_in(xtal_lock_in),
    .tune_high_in(tune_high_in), .diff_clock_out_p(diff_clock_out_p),
    .diff_clock_out_n(diff_clock_out_n), .monitor_pin_out(monitor_pin_out),
    .monitor_pin_oe(monitor_pin_oe), .coarse_load_trim(coarse_load_trim),
    .fine_tune_enable(fine_tune_enable), .lock_error(lock_error),
    .range_exceeded(range_exceeded));
`default_nettype wire

// *** dv/ppa_xtal_model.sv ***
// Crystal loop model: drifts out of range, then drops lock
`timescale 1ns/100ps
`default_nettype none
module ppa_xtal_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic lose_ref,
    input  wire logic drift_high,
    output logic      xtal_lock_in,
    output logic      tune_high_in,
    output logic      tune_low_in
);
    logic [1:0] age_reg;
    logic [1:0] age_next;
    always_comb
    begin
        age_next = 2'd0;
        if (lose_ref)
            age_next = (age_reg == 2'd3) ? 2'd3 : age_reg + 2'd1;
    end
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            age_reg <= 2'd0;
        else
            age_reg <= age_next;
    end
    // Range leaves first so direction is settled when lock falls
    assign xtal_lock_in = age_reg < 2'd2;
    assign tune_high_in = age_reg != 2'd0 && drift_high;
    assign tune_low_in  = age_reg != 2'd0 && !drift_high;
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Testbench for the phase adjust and monitor block
`timescale 1ns/100ps
`default_nettype none
`include "ppa_defines.svh"
module tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic       lose_ref = 1'b0;
    logic       drift_high = 1'b1;
    logic [7:0] rdata;
    logic       xl, th, tl, dp, dn, mp, moe, fine, lerr, rng, pv;
    logic [3:0] trim;
    int         n_errors = 0;
    int         tests_run = 0;
    int         cyc = 0;
    int         nr;
    time        t;
    always #25 clk = ~clk;
    ppa_xtal_model xtal_u (.clk(clk), .rst(rst), .lose_ref(lose_ref),
        .drift_high(drift_high), .xtal_lock_in(xl), .tune_high_in(th), .tune_low_in(tl));
    ppa_phase_adjust dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .xtal_lock_in(xl),
        .tune_high_in(th), .tune_low_in(tl), .diff_clock_out_p(dp), .diff_clock_out_n(dn),
        .monitor_pin_out(mp), .monitor_pin_oe(moe), .coarse_load_trim(trim),
        .fine_tune_enable(fine), .lock_error(lerr), .range_exceeded(rng));
    task automatic final_report;
        $display("checks=%0d errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Hang guard, far above the several hundred cycles needed
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 8000)
        begin
            n_errors++;
            final_report;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rdata & m, e);
    endtask
    // Write control mid-period, then count cycles over k output periods
    task automatic periods(input logic [7:0] c, input int k, input logic [7:0] e);
        @(posedge dp);
        t = $time;
        wr(`PPA_REG_CTRL, c);
        repeat (k) @(posedge dp);
        chk(8'(($time - t) / 50), e);
    endtask
    // Count monitor rises over n cycles; window must be a whole number of periods
    task automatic rises(input int n, input logic [7:0] e);
        repeat (30) @(posedge clk);
        #1;
        nr = 0;
        pv = mp;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            if (mp && !pv)
                nr++;
            pv = mp;
        end
        chk(8'(nr), e);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd(`PPA_REG_CTRL, 8'hf7, 8'h00);
        rd(`PPA_REG_TRIM, 8'hff, 8'h00);
        rd(`PPA_REG_NP1, 8'hff, 8'h01);
        rd(`PPA_REG_FBDIV, 8'hff, 8'h01);
        rd(4'hf, 8'hff, 8'h00);
        wr(`PPA_REG_TRIM, 8'hfa);
        rd(`PPA_REG_TRIM, 8'hff, 8'h0a);
        chk({4'h0, trim}, 8'h0a);
        wr(`PPA_REG_CTRL, 8'h20);
        repeat (2) @(posedge clk);
        chk({7'h0, fine}, 8'h01);
        chk({7'h0, moe}, 8'h00);
        $display("test registers done");
        wr(`PPA_REG_CTRL, 8'h00);
        wr(`PPA_REG_NP1, 8'h03);
        repeat (3) @(posedge dp);
        @(posedge dp);
        t = $time;
        @(negedge dp);
        chk(8'(($time - t) / 50), 8'h02);
        periods(8'h00, 8, 8'h18);
        periods(8'h01, 8, 8'h19);
        periods(8'h00, 8, 8'h18);
        periods(8'h01, 8, 8'h19);
        wr(`PPA_REG_NP1, 8'h02);
        wr(`PPA_REG_NP2, 8'h03);
        wr(`PPA_REG_NP3, 8'h02);
        repeat (3) @(posedge dp);
        periods(8'h00, 4, 8'h30);
        $display("test divider and slip done");
        wr(`PPA_REG_CTRL, 8'h10);
        repeat (8) @(posedge clk);
        chk({7'h0, mp}, 8'h01);
        rd(`PPA_REG_CTRL, 8'h08, 8'h08);
        lose_ref <= 1'b1;
        repeat (10) @(posedge clk);
        chk({6'h0, lerr, rng}, 8'h03);
        chk({7'h0, mp}, 8'h00);
        rd(`PPA_REG_CTRL, 8'h08, 8'h00);
        rd(`PPA_REG_STATUS, 8'h0b, 8'h0a);
        wr(`PPA_REG_CTRL, 8'h14);
        repeat (4) @(posedge clk);
        chk({7'h0, mp}, 8'h01);
        rd(`PPA_REG_CTRL, 8'h08, 8'h08);
        lose_ref <= 1'b0;
        repeat (10) @(posedge clk);
        chk({6'h0, lerr, mp}, 8'h01);
        drift_high <= 1'b0;
        lose_ref <= 1'b1;
        repeat (10) @(posedge clk);
        chk({7'h0, mp}, 8'h00);
        rd(`PPA_REG_STATUS, 8'h0b, 8'h08);
        $display("test lock monitor done");
        lose_ref <= 1'b0;
        wr(`PPA_REG_FBDIV, 8'h04);
        wr(`PPA_REG_CTRL, 8'h1c);
        rises(40, 8'h0a);
        wr(`PPA_REG_FBDIV, 8'h02);
        wr(`PPA_REG_CTRL, 8'h1e);
        rises(96, 8'h04);
        wr(`PPA_REG_FBDIV, 8'h08);
        wr(`PPA_REG_CTRL, 8'h18);
        rises(96, 8'h04);
        wr(`PPA_REG_FBDIV, 8'h0c);
        repeat (40) @(posedge clk);
        rd(`PPA_REG_CTRL, 8'h08, {4'h0, mp, 3'h0});
        wr(`PPA_REG_CTRL, 8'h19);
        repeat (40) @(posedge clk);
        rd(`PPA_REG_CTRL, 8'h08, {4'h0, mp, 3'h0});
        wr(`PPA_REG_CTRL, 8'h0c);
        repeat (2) @(posedge clk);
        chk({7'h0, moe}, 8'h00);
        $display("test feedback monitor done");
        final_report;
    end
endmodule
`default_nettype wire
